// [verilog/uctl_pkg.sv]
/*
 * uctl_pkg: register offsets, field positions, reset values and
 * state types of the serial transceiver control block.
 * Assumes a byte-wide register port with a 3-bit address.
 */
package uctl_pkg;
   // register offsets
   localparam int            ADDR_W       = 3;
   localparam logic [2:0]    OFS_FORMAT   = 3'h0;
   localparam logic [2:0]    OFS_ENABLE   = 3'h1;
   localparam logic [2:0]    OFS_STATUS   = 3'h2;
   localparam logic [2:0]    OFS_DATA     = 3'h3;
   localparam logic [2:0]    OFS_BAUD_HI  = 3'h4;
   localparam logic [2:0]    OFS_BAUD_LO  = 3'h5;
   localparam logic [2:0]    OFS_CTRL3    = 3'h6;
   // uart_format_control fields
   localparam int            FM_LOOP      = 7;
   localparam int            FM_FREEZE    = 6;
   localparam int            FM_RX_SOURCE_SELECT      = 5;
   localparam int            FM_NINE      = 4;
   localparam int            FM_WAKE      = 3;
   localparam int            FM_ILT       = 2;
   localparam int            FM_PE        = 1;
   localparam int            FM_PT        = 0;
   // uart_enable_control fields
   localparam int            EN_TIE       = 7;
   localparam int            EN_TX_DONE_IRQ_EN      = 6;
   localparam int            EN_RIE       = 5;
   localparam int            EN_IDLE_IRQ_EN      = 4;
   localparam int            EN_TE        = 3;
   localparam int            EN_RE        = 2;
   localparam int            EN_RWU       = 1;
   localparam int            EN_SBK       = 0;
   // uart_main_status fields
   localparam int            ST_TX_BUF_EMPTY      = 7;
   localparam int            ST_TC        = 6;
   localparam int            ST_RX_BUF_FULL      = 5;
   localparam int            ST_IDLE      = 4;
   localparam int            ST_OVR       = 3;
   localparam int            ST_NF        = 2;
   localparam int            ST_FE        = 1;
   localparam int            ST_PF        = 0;
   // third control register fields
   localparam int            C3_R8        = 7;
   localparam int            C3_T8        = 6;
   localparam int            C3_DIR       = 5;
   // reset values
   localparam logic [7:0]    RST_STATUS   = 8'hC0;
   localparam logic [12:0]   RST_DIVISOR  = 13'h0004;
   // frame lengths in bit times, and sampling figures
   localparam logic [3:0]    FRAME_BITS_8 = 4'hA;
   localparam logic [3:0]    FRAME_BITS_9 = 4'hB;
   localparam logic [3:0]    SUB_LAST     = 4'hF;
   localparam logic [2:0]    START_SMPL   = 3'h7;
   localparam logic [2:0]    BIT_SMPL     = 3'h3;
   // engine states
   typedef enum logic [0:0] {TX_IDLE, TX_SEND}  uctl_tx_state_type;
   typedef enum logic [0:0] {RX_IDLE, RX_FRAME} uctl_rx_state_type;
endpackage : uctl_pkg

// [verilog/uctl_uart_core.sv]
/*
 * uctl_uart_core: control, status, transmitter and receiver of an
 * asynchronous serial transceiver, with pin routing.
 * Assumes registers reached over a plain strobe port on core_clk,
 * pins sampled through two flops, cpuWait from core_clk logic.
 */
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
module uctl_uart_core (
   // clock and reset
   input  wire logic                       core_clk,
   input  wire logic                       reset_n,
   // register port
   input  wire logic [uctl_pkg::ADDR_W-1:0] regAddr,
   input  wire logic [7:0]                 regWdata,
   input  wire logic                       regWrite,
   input  wire logic                       regRead,
   output      logic [7:0]                 regRdata,
   // system
   input  wire logic                       cpuWait,
   output      logic                       irqTx,
   output      logic                       irqRx,
   // pins
   input  wire logic                       rxPinIn,
   input  wire logic                       txPinIn,
   output      logic                       txPinOut,
   output      logic                       txPinOe,
   output      logic                       txPinOwned,
   output      logic                       rxPinOwned
);
   import uctl_pkg::*;

   // whole state of the block
   typedef struct packed {
      logic [7:0]        fmt;       // format control
      logic [7:0]        en;        // enable control
      logic [7:0]        flags;     // main status
      logic [7:0]        arm;       // flags seen by last status read
      logic              swDir;     // single-wire direction
      logic              t8;        // ninth tx bit
      logic              r8;        // ninth rx bit
      logic [4:0]        bdHi;      // buffered divisor high half
      logic [12:0]       div;       // working divisor
      logic [12:0]       baudCnt;   // prescale counter
      logic [7:0]        txBuf;     // transmit buffer
      logic [7:0]        rxData;    // receive buffer
      logic [7:0]        rdata;     // read data, one cycle late
      uctl_tx_state_type txSt;
      logic [10:0]       txSh;      // transmit shifter, lsb on line
      logic [3:0]        txSub;     // sixteenth of bit
      logic [3:0]        txBit;     // bit index in frame
      logic              prePend;   // queued idle character
      logic              brkPend;   // queued break
      logic              rxS1;      // rx pin sync stage 1
      logic              rxS2;      // rx pin sync stage 2
      logic              txS1;      // tx pin sync stage 1
      logic              txS2;      // tx pin sync stage 2
      uctl_rx_state_type rxSt;
      logic [3:0]        rxSub;
      logic [3:0]        rxBit;     // 0 start, then data, then stop
      logic [2:0]        rxOnes;    // ones among samples of a bit
      logic [8:0]        rxSh;      // received data bits
      logic              rxNoise;
      logic [3:0]        idleSub;
      logic [3:0]        idleBits;  // high bit times counted
      logic              idleArmed;
   } uctl_state_type;

   uctl_state_type r;      // registered state
   uctl_state_type n;      // next state

   // combinational helpers
   logic       tick;       // one sixteenth of a bit time
   logic       run;        // baud generator needed
   logic       loop;
   logic       single;
   logic       nine;
   logic [3:0] frameBits;
   logic       rxLine;     // receiver input after routing
   logic       smpl;       // sampling point in current bit
   logic       bitVal;     // majority value of finished bit
   logic [8:0] txWord;     // data with optional parity
   logic       deliver;    // finished character goes to buffer
   logic       msb;
   logic       txBusy;

   // pin routing, shared by outputs and receiver
   assign loop      = r.fmt[FM_LOOP];
   assign single    = loop & r.fmt[FM_RX_SOURCE_SELECT];
   assign nine      = r.fmt[FM_NINE];
   assign frameBits = nine ? FRAME_BITS_9 : FRAME_BITS_8;
   assign txBusy    = (r.txSt != TX_IDLE) | r.prePend | r.brkPend;

   // receiver source: pin, tx pin, or transmitter output
   always_comb begin : rx_route
      if (!loop) begin
         rxLine = r.rxS2;
      end else if (single && !r.swDir) begin
         rxLine = r.txS2;
      end else begin
         rxLine = r.txSh[0];
      end
   end

   // pin ownership; a disabled transmitter still finishes its queue
   assign txPinOwned = (r.en[EN_TE] | txBusy) & ~(loop & ~r.fmt[FM_RX_SOURCE_SELECT]);
   assign txPinOe    = txPinOwned & (~single | r.swDir);
   assign txPinOut   = r.txSh[0];
   assign rxPinOwned = r.en[EN_RE] & ~loop;
   assign regRdata   = r.rdata;

   // interrupt requests, level while flag and enable are both set
   assign irqTx = (r.en[EN_TIE] & r.flags[ST_TX_BUF_EMPTY]) | (r.en[EN_TX_DONE_IRQ_EN] & r.flags[ST_TC]);
   assign irqRx = (r.en[EN_RIE] & r.flags[ST_RX_BUF_FULL]) | (r.en[EN_IDLE_IRQ_EN] & r.flags[ST_IDLE]);

   // sampling points: seven in the start bit, three in the others
   always_comb begin : sample_points
      if (r.rxBit == 4'h0) begin
         smpl = (r.rxSub == 4'h3) | (r.rxSub == 4'h5) | (r.rxSub >= 4'h7 && r.rxSub <= 4'hB);
         bitVal = r.rxOnes > (START_SMPL >> 1);
      end else begin
         smpl = (r.rxSub >= 4'h8) && (r.rxSub <= 4'hA);
         bitVal = r.rxOnes > (BIT_SMPL >> 1);
      end
   end

   // transmit word with parity put in the top data bit
   always_comb begin : tx_parity
      txWord = {r.t8, r.txBuf};
      if (r.fmt[FM_PE]) begin
         if (nine) begin
            txWord[8] = (^r.txBuf) ^ r.fmt[FM_PT];
         end else begin
            txWord[7] = (^r.txBuf[6:0]) ^ r.fmt[FM_PT];
         end
      end
   end

   // next state: bus first, then engines, so hardware sets win
   always_comb begin : next_state
      n = r;
      tick = 1'b0;
      deliver = 1'b0;
      msb = nine ? r.rxSh[8] : r.rxSh[7];
      n.rdata = 8'h00;
      n.rxS1 = rxPinIn;
      n.rxS2 = r.rxS1;
      n.txS1 = txPinIn;
      n.txS2 = r.txS1;
      run = r.en[EN_TE] | r.en[EN_RE] | txBusy;

      // register reads; unmapped offsets read zero
      if (regRead) begin
         case (regAddr)
            OFS_FORMAT:  n.rdata = r.fmt;
            OFS_ENABLE:  n.rdata = r.en;
            OFS_STATUS: begin
               n.rdata = r.flags;
               n.arm = r.flags;
            end
            OFS_DATA: begin
               n.rdata = r.rxData;
               // armed receive flags clear on the data read
               n.flags[5:0] = r.flags[5:0] & ~r.arm[5:0];
               n.arm[5:0] = 6'h00;
            end
            OFS_BAUD_HI: n.rdata = {3'h0, r.div[12:8]};
            OFS_BAUD_LO: n.rdata = r.div[7:0];
            OFS_CTRL3:   n.rdata = {r.r8, r.t8, r.swDir, 5'h00};
            default:     n.rdata = 8'h00;
         endcase
      end

      // register writes; status offset ignores them
      if (regWrite) begin
         case (regAddr)
            OFS_FORMAT: n.fmt = regWdata;
            OFS_ENABLE: begin
               n.en = regWdata;
               // queue an idle character on a tx_on rising write
               if (!r.en[EN_TE] && regWdata[EN_TE]) begin
                  n.prePend = 1'b1;
                  if (r.arm[ST_TC]) begin
                     n.flags[ST_TC] = 1'b0;
                     n.arm[ST_TC] = 1'b0;
                  end
               end
               // a rising send-break write queues one break
               if (!r.en[EN_SBK] && regWdata[EN_SBK]) begin
                  n.brkPend = 1'b1;
               end
               if (regWdata[EN_SBK] && r.arm[ST_TC]) begin
                  n.flags[ST_TC] = 1'b0;
                  n.arm[ST_TC] = 1'b0;
               end
            end
            OFS_DATA: begin
               n.txBuf = regWdata;
               n.flags[7:6] = r.flags[7:6] & ~r.arm[7:6];
               n.arm[7:6] = 2'h0;
            end
            OFS_BAUD_HI: n.bdHi = regWdata[4:0];
            OFS_BAUD_LO: n.div = {r.bdHi, regWdata};
            OFS_CTRL3: begin
               n.t8 = regWdata[C3_T8];
               n.swDir = regWdata[C3_DIR];
            end
            default: n.fmt = r.fmt;                               // status and holes: no effect
         endcase
      end

      // baud prescaler: bus clock / (16 x divisor), held while frozen
      if (r.div == 13'h0000 || !run) begin
         n.baudCnt = 13'h0000;
      end else if (!(r.fmt[FM_FREEZE] && cpuWait)) begin
         if (r.baudCnt >= r.div - 13'h0001) begin
            n.baudCnt = 13'h0000;
            tick = 1'b1;
         end else begin
            n.baudCnt = r.baudCnt + 13'h0001;
         end
      end

      // transmitter: idle character, then break, then data
      case (r.txSt)
         TX_IDLE: begin
            n.txSh = 11'h7FF;
            n.txSub = 4'h0;
            n.txBit = 4'h0;
            if (r.prePend) begin
               n.prePend = 1'b0;
               n.txSt = TX_SEND;
            end else if (r.brkPend || r.en[EN_SBK]) begin
               n.brkPend = 1'b0;
               n.txSh = 11'h000;
               n.txSt = TX_SEND;
            end else if (r.en[EN_TE] && !r.flags[ST_TX_BUF_EMPTY]) begin
               // start bit, data lsb first, optional ninth, stop
               n.txSh = nine ? {1'b1, txWord, 1'b0} : {2'h3, txWord[7:0], 1'b0};
               n.flags[ST_TX_BUF_EMPTY] = 1'b1;
               n.txSt = TX_SEND;
            end
         end
         TX_SEND: begin
            if (tick) begin
               n.txSub = r.txSub + 4'h1;
               if (r.txSub == SUB_LAST) begin
                  n.txSh = {1'b1, r.txSh[10:1]};
                  n.txBit = r.txBit + 4'h1;
                  if (r.txBit == frameBits - 4'h1) begin
                     n.txSh = 11'h7FF;
                     n.txSt = TX_IDLE;
                  end
               end
            end
         end
         default: n.txSt = TX_IDLE;
      endcase

      // receiver: off clears the engine
      if (!r.en[EN_RE]) begin
         n.rxSt = RX_IDLE;
         n.idleSub = 4'h0;
      end else begin
         case (r.rxSt)
            RX_IDLE: begin
               if (tick) begin
                  n.idleSub = r.idleSub + 4'h1;
                  if (!rxLine) begin
                     // falling edge: begin start bit
                     n.rxSt = RX_FRAME;
                     n.rxSub = 4'h1;
                     n.rxBit = 4'h0;
                     n.rxOnes = 3'h0;
                     n.rxNoise = 1'b0;
                     n.idleBits = 4'h0;
                     n.idleSub = 4'h0;
                  end else if (r.idleSub == SUB_LAST && r.idleBits < frameBits) begin
                     n.idleBits = r.idleBits + 4'h1;
                     // full character time of high line, once
                     if (r.idleBits + 4'h1 == frameBits) begin
                        if (r.idleArmed && !r.en[EN_RWU]) begin
                           n.flags[ST_IDLE] = 1'b1;
                           n.idleArmed = 1'b0;
                        end
                        if (r.en[EN_RWU] && !r.fmt[FM_WAKE]) begin
                           n.en[EN_RWU] = 1'b0;
                        end
                     end
                  end
               end
            end
            RX_FRAME: begin
               if (tick) begin
                  n.rxSub = r.rxSub + 4'h1;
                  if (smpl && rxLine) begin
                     n.rxOnes = r.rxOnes + 3'h1;
                  end
                  if (r.rxSub == SUB_LAST) begin
                     n.rxOnes = 3'h0;
                     // any split vote within a bit is noise
                     if (r.rxOnes != 3'h0 && r.rxOnes != (r.rxBit == 4'h0 ? START_SMPL : BIT_SMPL)) begin
                        n.rxNoise = 1'b1;
                     end
                     n.rxBit = r.rxBit + 4'h1;
                     // idle count: after start bit, or after stop
                     if (r.rxBit != 4'h0) begin
                        n.idleBits = (bitVal && !r.fmt[FM_ILT]) ? r.idleBits + 4'h1 : 4'h0;
                     end
                     if (r.rxBit == 4'h0 && bitVal) begin
                        n.rxSt = RX_IDLE;                         // false start
                     end else if (r.rxBit != 4'h0 && r.rxBit < frameBits - 4'h1) begin
                        n.rxSh[r.rxBit - 4'h1] = bitVal;
                     end else if (r.rxBit == frameBits - 4'h1) begin
                        n.rxSt = RX_IDLE;
                        n.idleSub = 4'h0;
                        deliver = 1'b1;
                        // standby drops characters until wake
                        if (r.en[EN_RWU]) begin
                           deliver = 1'b0;
                           if (r.fmt[FM_WAKE] && msb) begin
                              n.en[EN_RWU] = 1'b0;
                              deliver = 1'b1;
                           end
                        end
                        if (deliver) begin
                           if (n.flags[ST_RX_BUF_FULL]) begin
                              n.flags[ST_OVR] = 1'b1;
                           end else begin
                              n.rxData = r.rxSh[7:0];
                              n.r8 = r.rxSh[8];
                              n.flags[ST_RX_BUF_FULL] = 1'b1;
                              n.idleArmed = 1'b1;
                              n.flags[ST_NF] = n.rxNoise;
                              n.flags[ST_FE] = ~bitVal;
                              // parity: total ones odd or even
                              n.flags[ST_PF] = r.fmt[FM_PE] &
                                 (((nine ? ^r.rxSh[8:0] : ^r.rxSh[7:0])) != r.fmt[FM_PT]);
                           end
                        end
                     end
                  end
               end
            end
            default: n.rxSt = RX_IDLE;
         endcase
      end

      // complete when buffer empty and nothing queued or sending
      if (n.flags[ST_TX_BUF_EMPTY] && n.txSt == TX_IDLE && !n.prePend && !n.brkPend && !n.en[EN_SBK]) begin
         n.flags[ST_TC] = 1'b1;
      end
   end

   // state register; reset values are constants only
   always_ff @(posedge core_clk or negedge reset_n) begin : state_reg
      if (!reset_n) begin
         r <= '0;
         r.flags <= RST_STATUS;
         r.div <= RST_DIVISOR;
         r.txSh <= 11'h7FF;
         r.rxS1 <= 1'b1;
         r.rxS2 <= 1'b1;
         r.txS1 <= 1'b1;
         r.txS2 <= 1'b1;
         r.txSt <= TX_IDLE;
         r.rxSt <= RX_IDLE;
      end else begin
         r <= n;
      end
   end
endmodule : uctl_uart_core

// [dv/uctl_uart_core_sva.sv]
/* uctl_uart_core_sva: port checks of the transceiver control block.
   Assumes binding to uctl_uart_core; control regs reset to zero. */
`timescale 1ns/10ps
module uctl_uart_core_sva (
   // clock and reset
   input wire logic                        core_clk,
   input wire logic                        reset_n,
   // register port
   input wire logic [uctl_pkg::ADDR_W-1:0] regAddr,
   input wire logic [7:0]                  regWdata,
   input wire logic                        regWrite,
   input wire logic                        regRead,
   input wire logic [7:0]                  regRdata,
   // irqs and pins
   input wire logic                        irqTx,
   input wire logic                        irqRx,
   input wire logic                        txPinOut,
   input wire logic                        txPinOe,
   input wire logic                        txPinOwned,
   input wire logic                        rxPinOwned
);
   import uctl_pkg::*;
   logic [7:0] fmt_r;   // copy of format control
   logic [7:0] en_r;    // copy of enable control, only software-owned bits used
   logic       intLoop; // internal loop, neither pin used
   logic       stRd;    // status read strobe
   assign intLoop = fmt_r[FM_LOOP] & ~fmt_r[FM_RX_SOURCE_SELECT];
   assign stRd = regRead && regAddr == OFS_STATUS;
   // shadow of software writes; the bits used here never change by hardware
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         fmt_r <= 8'h00;
         en_r <= 8'h00;
      end else if (regWrite && regAddr == OFS_FORMAT) begin
         fmt_r <= regWdata;
      end else if (regWrite && regAddr == OFS_ENABLE) begin
         en_r <= regWdata;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   chk_rx_pin_owner: assert property (rxPinOwned == (en_r[EN_RE] & ~fmt_r[FM_LOOP]))
      else $error("rx pin ownership wrong");
   chk_loop_no_pin: assert property (intLoop |-> !txPinOe && !txPinOwned)
      else $error("tx pin used in internal loop");
   chk_tx_pin_owner: assert property (en_r[EN_TE] && !intLoop |-> txPinOwned)
      else $error("tx pin not owned while enabled");
   chk_irq_tx_off: assert property (!en_r[EN_TIE] && !en_r[EN_TX_DONE_IRQ_EN] |-> !irqTx)
      else $error("tx irq while masked");
   chk_irq_rx_off: assert property (!en_r[EN_RIE] && !en_r[EN_IDLE_IRQ_EN] |-> !irqRx)
      else $error("rx irq while masked");
   chk_irq_tx_flag: assert property (stRd |=> $past(irqTx) == (regRdata[ST_TX_BUF_EMPTY] & en_r[EN_TIE] | regRdata[ST_TC] & en_r[EN_TX_DONE_IRQ_EN]))
      else $error("tx irq disagrees with flags");
   chk_irq_rx_flag: assert property (stRd |=> $past(irqRx) == (regRdata[ST_RX_BUF_FULL] & en_r[EN_RIE] | regRdata[ST_IDLE] & en_r[EN_IDLE_IRQ_EN]))
      else $error("rx irq disagrees with flags");
   chk_tc_line_high: assert property (stRd |=> !regRdata[ST_TC] || $past(txPinOut))
      else $error("complete while line low");
endmodule : uctl_uart_core_sva
bind uctl_uart_core uctl_uart_core_sva uctl_uart_core_sva_i (.core_clk, .reset_n, .regAddr, .regWdata, .regWrite,
   .regRead, .regRdata, .irqTx, .irqRx, .txPinOut, .txPinOe, .txPinOwned, .rxPinOwned);

// [dv/uctl_remote_dev.sv]
/* uctl_remote_dev: remote serial device on the tx and rx lines.
   Assumes divisor 1 (16 clocks a bit) and lines that idle high. */
`timescale 1ns/10ps
module uctl_remote_dev #(
   parameter int BIT_CLKS = 16 // clocks per bit
) (
   // clock
   input  wire logic       core_clk,
   // serial lines
   input  wire logic       txLine,
   output      logic       rxLine,
   // decoded traffic
   output      logic [7:0] lastByte,
   output      logic       lastStop,
   output      logic [7:0] byteCount
);
   initial begin
      rxLine = 1'b1;
      lastByte = 8'h00;
      lastStop = 1'b0;
      byteCount = 8'h00;
   end
   // decoder: resync on each start edge, sample mid-bit, lsb first
   always begin
      @(negedge txLine);
      repeat (BIT_CLKS / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CLKS) @(posedge core_clk);
         lastByte[i] = txLine;
      end
      repeat (BIT_CLKS) @(posedge core_clk);
      lastStop = txLine;
      byteCount++;
   end
   // one frame: start, data lsb first, chosen stop level; line idles high after
   task automatic send_frame(input logic [7:0] data, input logic stopBit);
      logic [9:0] bits;
      bits = {stopBit, data, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge core_clk);
         rxLine <= bits[i];
         repeat (BIT_CLKS - 1) @(posedge core_clk);
      end
      @(posedge core_clk);
      rxLine <= 1'b1;
      // the receiver ends its stop bit a few clocks late, behind its synchroniser
      repeat (BIT_CLKS / 4) @(posedge core_clk);
   endtask : send_frame
endmodule : uctl_remote_dev

// [dv/uctl_uart_core_bench.sv]
/* uctl_uart_core_bench: self-checking bench of the transceiver control block.
   Assumes a pull-up on the released tx pin and divisor 1 for speed. */
`timescale 1ns/10ps
module uctl_uart_core_bench;
   import uctl_pkg::*;
   typedef struct packed {logic [2:0] a; logic [7:0] w; logic [7:0] r; logic irq;} uctl_row_type;
   uctl_row_type rows [7] = '{'{OFS_FORMAT, 8'hA5, 8'hA5, 1'b0}, '{OFS_FORMAT, 8'h00, 8'h00, 1'b0},
      '{OFS_ENABLE, 8'hB0, 8'hB0, 1'b1}, '{OFS_ENABLE, 8'h40, 8'h40, 1'b1}, '{OFS_ENABLE, 8'h30, 8'h30, 1'b0},
      '{OFS_STATUS, 8'h00, 8'hC0, 1'b0}, '{3'h7, 8'hFF, 8'h00, 1'b0}};
   logic [23:0] par [4] = '{24'h00A6A6, 24'h030383, 24'h020303, 24'h020181}; // format, data, line byte
   logic       core_clk = 1'b0; // 50 MHz
   logic       reset_n = 1'b0;  // async, active low
   logic [2:0] regAddr = 3'h0;
   logic [7:0] regWdata = 8'h00;
   logic       regWrite = 1'b0;
   logic       regRead = 1'b0;
   logic       cpuWait = 1'b0;  // cpu wait mode
   logic [7:0] regRdata, lastByte, byteCount, rdv, cnt;
   logic       irqTx, irqRx, rxLine, txPinOut, txPinOe, txPinOwned, rxPinOwned, lastStop, txWire;
   int         miscompares = 0, cmp_count = 0, cycles = 0;
   assign txWire = txPinOe ? txPinOut : 1'b1; // released pin pulled up
   always #10 core_clk = ~core_clk;
   uctl_uart_core uctl_uart_core_i (.core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .cpuWait(cpuWait),
      .irqTx(irqTx), .irqRx(irqRx), .rxPinIn(rxLine), .txPinIn(txWire), .txPinOut(txPinOut),
      .txPinOe(txPinOe), .txPinOwned(txPinOwned), .rxPinOwned(rxPinOwned));
   uctl_remote_dev uctl_remote_dev_i (.core_clk(core_clk), .txLine(txWire), .rxLine(rxLine),
      .lastByte(lastByte), .lastStop(lastStop), .byteCount(byteCount));
   // compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge core_clk);
      regWrite <= 1'b0;
   endtask : wr
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [2:0] a);
      @(posedge core_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1 rdv = regRdata;
   endtask : rd
   task automatic wait_bits(input int n);
      repeat (n * 16) @(posedge core_clk);
   endtask : wait_bits
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : final_report
   // hang guard, far above the expected run
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         final_report();
      end
   end
   initial begin
      repeat (6) @(posedge core_clk);
      reset_n <= 1'b1;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a);
         check(rdv, rows[i].r);
         check({7'h00, irqTx}, {7'h00, rows[i].irq});
      end
      wr(OFS_BAUD_HI, 8'h00);
      wr(OFS_BAUD_LO, 8'h01);
      wr(OFS_ENABLE, 8'h08);
      foreach (par[i]) begin
         wr(OFS_FORMAT, par[i][23:16]);
         rd(OFS_STATUS);
         wr(OFS_DATA, par[i][15:8]);
         rd(OFS_STATUS);
         check(rdv & 8'h40, 8'h00);
         for (int n = 0; n < 40 && rdv[ST_TC] !== 1'b1; n++) begin
            wait_bits(1);
            rd(OFS_STATUS);
         end
         check(rdv, 8'hC0);
         check(lastByte, par[i][7:0]);
         check({7'h00, lastStop}, 8'h01);
      end
      wr(OFS_FORMAT, 8'h00);
      wr(OFS_ENABLE, 8'h0C);
      uctl_remote_dev_i.send_frame(8'h5A, 1'b1);
      rd(OFS_STATUS);
      check(rdv & 8'hEF, 8'hE0);
      rd(OFS_DATA);
      check(rdv, 8'h5A);
      wait_bits(12);
      rd(OFS_STATUS);
      check(rdv, 8'hD0);
      rd(OFS_DATA);
      wait_bits(12);
      rd(OFS_STATUS);
      check(rdv, 8'hC0);
      uctl_remote_dev_i.send_frame(8'h33, 1'b0);
      rd(OFS_STATUS);
      check(rdv & 8'hEF, 8'hE2);
      rd(OFS_DATA);
      uctl_remote_dev_i.send_frame(8'h11, 1'b1);
      uctl_remote_dev_i.send_frame(8'h22, 1'b1);
      rd(OFS_STATUS);
      check(rdv & 8'hEF, 8'hE8);
      rd(OFS_DATA);
      check(rdv, 8'h11);
      uctl_remote_dev_i.send_frame(8'h44, 1'b1);
      rd(OFS_DATA);
      rd(OFS_STATUS);
      check(rdv & 8'hEF, 8'hE0);
      rd(OFS_DATA);
      cnt = byteCount;
      wr(OFS_FORMAT, 8'h80);
      rd(OFS_STATUS);
      wr(OFS_DATA, 8'h3C);
      wait_bits(14);
      rd(OFS_STATUS);
      rd(OFS_DATA);
      check(rdv, 8'h3C);
      check(byteCount, cnt);
      // frozen prescaler in wait mode: a loaded frame must not finish
      wr(OFS_FORMAT, 8'hC0);
      cpuWait <= 1'b1;
      rd(OFS_STATUS);
      wr(OFS_DATA, 8'h55);
      wait_bits(14);
      rd(OFS_STATUS);
      check(rdv & 8'hEF, 8'h80);
      @(posedge core_clk);
      cpuWait <= 1'b0;
      wait_bits(14);
      rd(OFS_STATUS);
      check(rdv & 8'hEF, 8'hE0);
      rd(OFS_DATA);
      check(rdv, 8'h55);
      reset_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      rd(OFS_STATUS);
      check(rdv, 8'hC0);
      final_report();
   end
endmodule : uctl_uart_core_bench
